// ### gnss_ref_model.sv
// model of the satellite time reference that gives leap second notice
`timescale 1ns/1ns
module gnss_ref_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic announce,
  input wire logic neg_req,
  input wire logic leap_armed,
  output logic leap_pending,
  output logic leap_negative
);
  logic armed_q;
  // ==========================================
  // notice raised ahead, cleared once the second has been taken
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      leap_pending <= 1'b0;
      leap_negative <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      armed_q <= leap_armed;
      if (announce) begin
        leap_pending <= 1'b1;
        leap_negative <= neg_req;
      end else if (leap_pending && armed_q && !leap_armed) begin
        leap_pending <= 1'b0;
        leap_negative <= ~leap_negative;
      end
    end
  end
endmodule // gnss_ref_model

// ### tb_top.sv
// self-checking bench for the time code counter
`timescale 1ns/1ns
module tb_top;
  import tctod_pkg::*;
  logic ref_clk, rst_n, frame_tick, drop_en, ref_load, leap_year, summer_neg, summer_mode_wr;
  logic [5:0] fps_last, ref_minutes, ref_seconds, ref_frames, summer_minutes, once_minutes;
  logic [5:0] start_minutes, end_minutes, jam_minutes, leap_minutes, tc_minutes, tc_seconds;
  logic [5:0] tc_frames;
  logic [4:0] ref_hours, ref_mday, summer_hours, once_mday, once_hours, start_hours, end_hours;
  logic [4:0] jam_hours, leap_hours, tc_hours, date_mday;
  logic [3:0] ref_month, once_month, start_month, end_month, date_month;
  logic [2:0] ref_wday, start_wday, start_ord, end_wday, end_ord, date_wday;
  logic signed [11:0] tz_offset_min;
  logic jam_en, jam_four, leap_pending, leap_negative, tc_drop, summer_on, leap_armed, jam_done;
  logic announce, neg_req;
  summer_mode_t summer_mode_set, summer_mode;
  leap_mode_t leap_mode;
  int err_total = 0, checked = 0, seed = 70273, off = 2, ja = 1;
  int h = 0, m = 0, s = 0, f = 0, son = 0, sm = 0, lo = 0, tz = 0, du = 0, k;

  timecode_time_of_day_adjust u_timecode_time_of_day_adjust (.*);
  gnss_ref_model u_gnss_ref_model (.ref_clk(ref_clk), .rst_n(rst_n), .announce(announce),
    .neg_req(neg_req), .leap_armed(leap_armed), .leap_pending(leap_pending),
    .leap_negative(leap_negative));

  initial begin
    ref_clk = 0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ==========================================
  // checks
  task automatic fail(string msg);
    $display("unexpected at %0t: %s", $time, msg);
    err_total++;
  endtask
  task automatic cmp_time();
    checked++;
    if (tc_hours !== h[4:0] || tc_minutes !== m[5:0] || tc_seconds !== s[5:0]
        || tc_frames !== f[5:0])
      fail($sformatf("time %0d:%0d:%0d:%0d want %0d:%0d:%0d:%0d", tc_hours, tc_minutes,
        tc_seconds, tc_frames, h, m, s, f));
  endtask
  task automatic cmp_flag(logic got, logic exp, string what);
    checked++;
    if (got !== exp) fail(what);
  endtask
  task automatic report_and_stop();
    if (err_total == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ==========================================
  // reference model, one frame
  task automatic mstep();
    int lw;
    f++;
    if (f > fps_last) begin
      f = 0;
      s++;
      lw = lo != 0 && (leap_mode == LM_UTC ? h == 23 && m == 59
        : du && h * 60 + m + 1 == leap_hours * 60 + leap_minutes);
      if (s > (lw ? (lo == 1 ? 60 : 58) : 59)) begin
        s = 0;
        if (lw) begin
          lo = 0;
          du = 0;
        end
        m++;
        if (m == 60) begin
          m = 0;
          h = (h + 1) % 24;
        end
        // deferred leap becomes due once local midnight has passed
        if (lo != 0 && h == 0 && m == 0) du = 1;
        if (drop_en && m % 10 != 0) f = fps_last > 29 ? 4 : 2;
        if (jam_en && ja == 1 && h == jam_hours && m == jam_minutes) begin
          f += jam_four ? 4 : 2;
          ja = 0;
        end else if (h == (jam_hours + 12) % 24 && m == jam_minutes) ja = 1;
        if (sm == 1 && h == once_hours && m == once_minutes) begin
          h = (h + 24 + (summer_neg ? -off : off)) % 24;
          sm = 0;
          son = !summer_neg;
        end else if (sm == 2 && son == 0 && h == start_hours && m == start_minutes) begin
          h = (h + off) % 24;
          son = 1;
        end else if (sm == 2 && son == 1 && h == end_hours && m == end_minutes) begin
          h = (h + 24 - off) % 24;
          son = 0;
        end
      end
    end
  endtask

  // ==========================================
  // stimulus
  task automatic load(int uh, int um, int us, int uf, int mo, int md, int wd);
    int t;
    @(posedge ref_clk);
    ref_load <= 1;
    {ref_hours, ref_minutes, ref_seconds, ref_frames} <= {uh[4:0], um[5:0], us[5:0], uf[5:0]};
    {ref_month, ref_mday, ref_wday} <= {mo[3:0], md[4:0], wd[2:0]};
    tz_offset_min <= tz[11:0];
    @(posedge ref_clk);
    ref_load <= 0;
    #1;
    t = (uh * 60 + um + tz + son * off * 60 + 2880) % 1440;
    h = t / 60;
    m = t % 60;
    s = us;
    f = uf;
    cmp_time();
  endtask
  task automatic ticks(int n);
    @(posedge ref_clk);
    frame_tick <= 1;
    for (int i = 1; i <= n; i++) begin
      @(posedge ref_clk);
      if (i == n) frame_tick <= 0;
      #1;
      mstep();
      cmp_time();
    end
  endtask
  task automatic set_mode(summer_mode_t md, logic neg);
    @(posedge ref_clk);
    summer_mode_wr <= 1;
    summer_mode_set <= md;
    summer_neg <= neg;
    summer_hours <= off[4:0];
    @(posedge ref_clk);
    summer_mode_wr <= 0;
    sm = md;
    if (md == SM_OFF) son = 0;
  endtask

  initial begin
    {frame_tick, drop_en, ref_load, summer_neg, summer_mode_wr, jam_en, jam_four} = '0;
    {announce, neg_req, leap_year, leap_hours, leap_minutes, summer_minutes} = '0;
    {ref_hours, ref_minutes, ref_seconds, ref_frames, ref_mday, ref_wday} = '0;
    {ref_month, tz_offset_min, fps_last, summer_hours} = {4'h1, 12'h000, 6'h1d, 5'h02};
    {once_month, once_mday, once_hours, once_minutes} = {4'h5, 5'h0a, 5'h03, 6'h00};
    {start_wday, start_ord, start_month, start_hours, start_minutes} = {3'h0, 3'h2, 4'h3, 5'h02,
      6'h00};
    {end_wday, end_ord, end_month, end_hours, end_minutes} = {6'h01, 4'hb, 5'h02, 6'h00};
    {jam_hours, jam_minutes} = {5'h02, 6'h00};
    leap_mode = LM_UTC;
    summer_mode_set = SM_OFF;
    rst_n = 0;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1;
    #1;
    cmp_time();
    cmp_flag(date_month === 4'h1 && date_mday === 5'h01 && date_wday === 3'h0
      && summer_mode === SM_OFF && {summer_on, leap_armed, jam_done} === 3'b000, 1'b1, "reset");
    // random zone, schedule off
    tz = $random(seed) % 721;
    load($unsigned($random(seed)) % 24, $unsigned($random(seed)) % 60, 58, 27, 1, 1, 0);
    ticks(40);
    tz = 0;
    // drop, ten-minute mark, 59.94 and integer rate
    for (k = 0; k < 4; k++) begin
      @(posedge ref_clk);
      drop_en <= k != 3;
      fps_last <= k == 2 ? 6'h3b : (k == 3 ? 6'h18 : 6'h1d);
      load(12, k == 1 ? 9 : 7, 59, k == 2 ? 59 : (k == 3 ? 24 : 29), 1, 1, 0);
      ticks(1);
      cmp_flag(tc_drop, drop_en, "drop flag");
    end
    @(posedge ref_clk);
    drop_en <= 1;
    fps_last <= 6'h1d;
    load(0, 0, 0, 0, 1, 1, 0);
    ticks(17982);
    cmp_flag(tc_minutes === 6'h0a && {tc_seconds, tc_frames} === 12'h000, 1'b1, "count");
    // daily jam, both skip sizes, once per day
    @(posedge ref_clk);
    jam_en <= 1;
    for (k = 0; k < 2; k++) begin
      @(posedge ref_clk);
      jam_four <= k[0];
      load(13, 59, 59, 29, 1, 1, 0);
      ticks(1);
      load(1, 59, 59, 29, 1, 1, 0);
      ticks(1);
      ja = jam_done;
      repeat (3) begin
        @(posedge ref_clk);
        #1;
        ja += jam_done;
      end
      cmp_flag(ja == 1, 1'b1, "jam pulse");
      ja = 0;
      load(1, 59, 59, 29, 1, 1, 0);
      ticks(1);
    end
    @(posedge ref_clk);
    jam_en <= 0;
    // one-shot, positive then negative offset
    for (k = 0; k < 2; k++) begin
      off = 1 + $unsigned($random(seed)) % 3;
      set_mode(SM_ONCE, k[0]);
      load((26 - son * off) % 24, 59, 59, 29, 5, 10, 2);
      ticks(1);
      cmp_flag(summer_mode === summer_mode_t'(sm) && summer_on === son[0], 1'b1, "once");
    end
    off = 1;
    set_mode(SM_OFF, 1'b0);
    set_mode(SM_RECUR, 1'b0);
    // recurring, second and last sunday
    for (k = 0; k < 2; k++) begin
      @(posedge ref_clk);
      start_ord <= k ? 3'h5 : 3'h2;
      load((25 - son * off) % 24, 59, 59, 29, 3, k ? 29 : 8, 0);
      ticks(1);
      cmp_flag(summer_on, son[0], "start");
      load((25 - son * off) % 24, 59, 59, 29, 11, 1, 0);
      ticks(1);
      cmp_flag(summer_on, son[0], "end");
    end
    // leap second, inserted, removed, then inserted at a deferred local time
    for (k = 0; k < 3; k++) begin
      @(posedge ref_clk);
      announce <= 1;
      neg_req <= k[0];
      leap_mode <= k == 2 ? LM_DEFER : LM_UTC;
      leap_hours <= 5'h04;
      @(posedge ref_clk);
      announce <= 0;
      lo = k[0] ? 2 : 1;
      for (ja = 0; ja < 8 && leap_armed !== 1'b1; ja++) begin
        @(posedge ref_clk);
        #1;
      end
      cmp_flag(leap_armed, 1'b1, "not armed");
      if (leap_armed !== 1'b1) break;
      if (k == 2) begin
        load(23, 59, 59, 29, 6, 30, 4);
        ticks(1);
      end
      load(k == 2 ? 3 : 23, 59, 58, 0, 6, 30, 4);
      ticks(100);
      cmp_flag(leap_armed, 1'b0, "still owed");
      cmp_flag({date_month, date_mday, date_wday} === (k == 2 ? 12'h6f4 : 12'h70d), 1'b1,
        "date");
    end
    report_and_stop();
  end
endmodule // tb_top

// ### tctod_pkg.sv
// constants and types for the time-of-day and time code counter
package tctod_pkg;
  // ==========================================
  // field limits
  localparam logic [5:0] FPS30_LAST = 6'h1d;
  localparam logic [5:0] SEC_LAST = 6'h3b;
  localparam logic [5:0] SEC_LEAP = 6'h3c;
  localparam logic [5:0] SEC_NEG_LAST = 6'h3a;
  localparam logic [5:0] FRAME_ZERO = 6'h00;
  localparam logic [10:0] MIN_PER_HOUR = 11'h03c;
  localparam logic [10:0] MOD_LAST = 11'h59f;
  localparam logic [10:0] MOD_TEN = 11'h00a;
  localparam logic signed [13:0] DAY_S = 14'sh05a0;
  localparam logic signed [13:0] HALF_DAY_S = 14'sh02d0;
  localparam logic signed [13:0] ONE_S = 14'sh0001;
  // ==========================================
  // frame skips
  localparam logic [5:0] DROP_30 = 6'h02;
  localparam logic [5:0] DROP_60 = 6'h04;
  localparam logic [5:0] JAM_SKIP_2 = 6'h02;
  localparam logic [5:0] JAM_SKIP_4 = 6'h04;
  // ==========================================
  // calendar
  localparam logic [3:0] MON_FIRST = 4'h1;
  localparam logic [3:0] MON_LAST = 4'hc;
  localparam logic [3:0] MON_FEB = 4'h2;
  localparam logic [4:0] MDAY_FIRST = 5'h01;
  localparam logic [4:0] DIM_FEB = 5'h1c;
  localparam logic [4:0] DIM_FEB_LEAP = 5'h1d;
  localparam logic [4:0] DIM_SHORT = 5'h1e;
  localparam logic [4:0] DIM_LONG = 5'h1f;
  localparam logic [4:0] WEEK_DAYS = 5'h07;
  localparam logic [2:0] WDAY_LAST = 3'h6;
  localparam logic [2:0] ORD_LAST = 3'h5;
  // ==========================================
  // modes
  typedef enum logic [1:0] {
    SM_OFF = 2'b00,
    SM_ONCE = 2'b01,
    SM_RECUR = 2'b10
  } summer_mode_t;
  typedef enum logic {
    LM_UTC = 1'b0,
    LM_DEFER = 1'b1
  } leap_mode_t;
endpackage

// ### timecode_time_of_day_adjust.sv
// local time-of-day and drop-frame time code counter with scheduled adjustments
`timescale 1ns/1ns
module timecode_time_of_day_adjust (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic frame_tick,
  input wire logic [5:0] fps_last,
  input wire logic drop_en,
  input wire logic ref_load,
  input wire logic [4:0] ref_hours,
  input wire logic [5:0] ref_minutes,
  input wire logic [5:0] ref_seconds,
  input wire logic [5:0] ref_frames,
  input wire logic [3:0] ref_month,
  input wire logic [4:0] ref_mday,
  input wire logic [2:0] ref_wday,
  input wire logic leap_year,
  input wire logic signed [11:0] tz_offset_min,
  input wire logic summer_neg,
  input wire logic [4:0] summer_hours,
  input wire logic [5:0] summer_minutes,
  input wire logic summer_mode_wr,
  input wire tctod_pkg::summer_mode_t summer_mode_set,
  input wire logic [3:0] once_month,
  input wire logic [4:0] once_mday,
  input wire logic [4:0] once_hours,
  input wire logic [5:0] once_minutes,
  input wire logic [2:0] start_wday,
  input wire logic [2:0] start_ord,
  input wire logic [3:0] start_month,
  input wire logic [4:0] start_hours,
  input wire logic [5:0] start_minutes,
  input wire logic [2:0] end_wday,
  input wire logic [2:0] end_ord,
  input wire logic [3:0] end_month,
  input wire logic [4:0] end_hours,
  input wire logic [5:0] end_minutes,
  input wire logic jam_en,
  input wire logic jam_four,
  input wire logic [4:0] jam_hours,
  input wire logic [5:0] jam_minutes,
  input wire logic leap_pending,
  input wire logic leap_negative,
  input wire tctod_pkg::leap_mode_t leap_mode,
  input wire logic [4:0] leap_hours,
  input wire logic [5:0] leap_minutes,
  output logic [4:0] tc_hours,
  output logic [5:0] tc_minutes,
  output logic [5:0] tc_seconds,
  output logic [5:0] tc_frames,
  output logic tc_drop,
  output logic [3:0] date_month,
  output logic [4:0] date_mday,
  output logic [2:0] date_wday,
  output tctod_pkg::summer_mode_t summer_mode,
  output logic summer_on,
  output logic leap_armed,
  output logic jam_done
);
  import tctod_pkg::*;

  // ==========================================
  // helpers
  function automatic logic [10:0] mod_of(input logic [4:0] h, input logic [5:0] m);
    return 11'(11'(h) * MIN_PER_HOUR) + 11'(m);
  endfunction

  function automatic logic [10:0] wrap_day(input logic signed [13:0] v);
    logic signed [13:0] t;
    t = v;
    if (t < 0) t = t + DAY_S;
    if (t < 0) t = t + DAY_S;
    if (t >= DAY_S) t = t - DAY_S;
    if (t >= DAY_S) t = t - DAY_S;
    return t[10:0];
  endfunction

  function automatic logic signed [13:0] sx(input logic [10:0] v);
    return $signed({3'h0, v});
  endfunction

  function automatic logic [4:0] dim(input logic [3:0] m, input logic ly);
    case (m)
      MON_FEB: dim = ly ? DIM_FEB_LEAP : DIM_FEB;
      4'h4, 4'h6, 4'h9, 4'hb: dim = DIM_SHORT;
      default: dim = DIM_LONG;
    endcase
  endfunction

  // ==========================================
  // state
  logic [4:0] hours_q;
  logic [5:0] minutes_q, seconds_q, frames_q;
  logic [3:0] month_q;
  logic [4:0] mday_q;
  logic [2:0] wday_q;
  summer_mode_t smode_q;
  logic son_q, drop_q, jam_fired_q, jam_done_q;
  logic armed_q, neg_q, due_q, pend_q;

  // ==========================================
  // calendar rule match
  function automatic logic rule_day(input logic [2:0] wd, input logic [2:0] ord,
                                    input logic [3:0] mon);
    logic ord_ok;
    ord_ok = (ord == ORD_LAST) ? (6'(mday_q) + 6'(WEEK_DAYS) > 6'(dim(month_q, leap_year)))
                               : (5'(mday_q - MDAY_FIRST) / WEEK_DAYS == 5'(ord - 3'h1));
    return month_q == mon && wday_q == wd && ord_ok;
  endfunction

  // ==========================================
  // counting
  wire logic tick_ok = frame_tick & !ref_load;
  wire logic [10:0] cur_mod = mod_of(hours_q, minutes_q);
  wire logic [10:0] nxt_mod = (cur_mod == MOD_LAST) ? 11'h000 : 11'(cur_mod + 11'h001);
  wire logic [10:0] sum_mag = mod_of(summer_hours, summer_minutes);
  wire logic signed [13:0] son_min = son_q ? sx(sum_mag) : 14'sh0000;
  // local minute at which UTC midnight falls
  wire logic [10:0] utc_mid = wrap_day(14'(tz_offset_min) + son_min);
  wire logic [10:0] utc_pre = wrap_day(sx(utc_mid) - ONE_S);
  wire logic [10:0] lsch_pre = wrap_day(sx(mod_of(leap_hours, leap_minutes)) - ONE_S);
  wire logic leap_now = armed_q & ((leap_mode == LM_UTC) ? cur_mod == utc_pre
                                                         : due_q & cur_mod == lsch_pre);
  wire logic [5:0] sec_end = !leap_now ? SEC_LAST : neg_q ? SEC_NEG_LAST : SEC_LEAP;
  wire logic fr_wrap = frames_q == fps_last;
  wire logic sec_wrap = seconds_q == sec_end;
  wire logic min_roll = tick_ok & fr_wrap & sec_wrap;
  wire logic day_roll = min_roll & cur_mod == MOD_LAST;

  // ==========================================
  // frame skips at minute change
  wire logic ten_min = (nxt_mod % MOD_TEN) == 11'h000;
  wire logic [5:0] drop_n = (fps_last > FPS30_LAST) ? DROP_60 : DROP_30;
  wire logic [10:0] jam_mod = mod_of(jam_hours, jam_minutes);
  wire logic jam_hit = jam_en & !jam_fired_q & nxt_mod == jam_mod;
  wire logic [5:0] jam_skip = jam_four ? JAM_SKIP_4 : JAM_SKIP_2;
  wire logic [5:0] base_fr = (drop_en & !ten_min) ? drop_n : FRAME_ZERO;
  wire logic [5:0] first_fr = 6'(base_fr + (jam_hit ? jam_skip : FRAME_ZERO));
  wire logic jam_clr = min_roll & nxt_mod == wrap_day(sx(jam_mod) + HALF_DAY_S);

  // ==========================================
  // summer time schedule
  wire logic once_hit = smode_q == SM_ONCE && month_q == once_month && mday_q == once_mday
                        && nxt_mod == mod_of(once_hours, once_minutes);
  wire logic start_hit = smode_q == SM_RECUR && !son_q
                         && rule_day(start_wday, start_ord, start_month)
                         && nxt_mod == mod_of(start_hours, start_minutes);
  wire logic end_hit = smode_q == SM_RECUR && son_q
                       && rule_day(end_wday, end_ord, end_month)
                       && nxt_mod == mod_of(end_hours, end_minutes);
  wire logic signed [13:0] once_off = summer_neg ? -sx(sum_mag) : sx(sum_mag);
  wire logic signed [13:0] shift = once_hit ? once_off : start_hit ? sx(sum_mag)
                                   : end_hit ? -sx(sum_mag) : 14'sh0000;
  wire logic [10:0] roll_mod = wrap_day(sx(nxt_mod) + shift);
  wire logic [10:0] load_mod = wrap_day(sx(mod_of(ref_hours, ref_minutes)) + 14'(tz_offset_min)
                                        + son_min);
  wire logic [10:0] new_mod = ref_load ? load_mod : roll_mod;
  wire logic [4:0] dmax = dim(month_q, leap_year);

  // ==========================================
  // time of day
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hours_q <= '0;
      minutes_q <= '0;
      seconds_q <= '0;
      frames_q <= '0;
    end else if (ref_load || min_roll) begin
      hours_q <= 5'(new_mod / MIN_PER_HOUR);
      minutes_q <= 6'(new_mod % MIN_PER_HOUR);
      seconds_q <= ref_load ? ref_seconds : '0;
      frames_q <= ref_load ? ref_frames : first_fr;
    end else if (tick_ok) begin
      seconds_q <= fr_wrap ? 6'(seconds_q + 6'h01) : seconds_q;
      frames_q <= fr_wrap ? FRAME_ZERO : 6'(frames_q + 6'h01);
    end
  end

  // ==========================================
  // date
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      month_q <= MON_FIRST;
      mday_q <= MDAY_FIRST;
      wday_q <= '0;
    end else if (ref_load) begin
      month_q <= ref_month;
      mday_q <= ref_mday;
      wday_q <= ref_wday;
    end else if (day_roll) begin
      mday_q <= (mday_q == dmax) ? MDAY_FIRST : 5'(mday_q + 5'h01);
      month_q <= (mday_q != dmax) ? month_q : (month_q == MON_LAST) ? MON_FIRST
                 : 4'(month_q + 4'h1);
      wday_q <= (wday_q == WDAY_LAST) ? 3'h0 : 3'(wday_q + 3'h1);
    end
  end

  // ==========================================
  // schedules
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      smode_q <= SM_OFF;
      son_q <= 1'b0;
      drop_q <= 1'b0;
      jam_fired_q <= 1'b0;
      jam_done_q <= 1'b0;
    end else begin
      drop_q <= drop_en;
      jam_done_q <= min_roll & jam_hit;
      jam_fired_q <= (min_roll & jam_hit) | (jam_fired_q & !jam_clr);
      if (summer_mode_wr) begin
        smode_q <= summer_mode_set;
      end else if (min_roll && once_hit) begin
        smode_q <= SM_OFF;
      end
      if (summer_mode_wr && summer_mode_set == SM_OFF) begin
        son_q <= 1'b0;
      end else if (min_roll && (once_hit || start_hit || end_hit)) begin
        son_q <= once_hit ? !summer_neg : start_hit;
      end
    end
  end

  // ==========================================
  // leap second tracking
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= 1'b0;
      armed_q <= 1'b0;
      neg_q <= 1'b0;
      due_q <= 1'b0;
    end else begin
      pend_q <= leap_pending;
      if (leap_pending && !pend_q) begin
        armed_q <= 1'b1;
        neg_q <= leap_negative;
        due_q <= 1'b0;
      end else if (min_roll && leap_now) begin
        armed_q <= 1'b0;
        due_q <= 1'b0;
      end else if (min_roll && armed_q && nxt_mod == utc_mid) begin
        due_q <= 1'b1;
      end
    end
  end

  assign tc_hours = hours_q;
  assign tc_minutes = minutes_q;
  assign tc_seconds = seconds_q;
  assign tc_frames = frames_q;
  assign tc_drop = drop_q;
  assign date_month = month_q;
  assign date_mday = mday_q;
  assign date_wday = wday_q;
  assign summer_mode = smode_q;
  assign summer_on = son_q;
  assign leap_armed = armed_q;
  assign jam_done = jam_done_q;

  // ==========================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_frame_count;
    tick_ok && !fr_wrap |=> frames_q == $past(frames_q) + 6'h01;
  endproperty
  a_frame_count: assert property (p_frame_count) else $error("frame did not step by one");

  property p_drop_skip;
    min_roll && drop_en && !ten_min && !jam_hit |=> frames_q == $past(drop_n);
  endproperty
  a_drop_skip: assert property (p_drop_skip) else $error("drop minute did not skip");

  property p_ten_min;
    min_roll && ten_min && !jam_hit |=> frames_q == FRAME_ZERO;
  endproperty
  a_ten_min: assert property (p_ten_min) else $error("tenth minute skipped frames");

  sequence s_jam_roll;
    min_roll && jam_hit && ten_min;
  endsequence
  property p_jam_skip;
    s_jam_roll |=> jam_done && frames_q == ($past(jam_four) ? JAM_SKIP_4 : JAM_SKIP_2);
  endproperty
  a_jam_skip: assert property (p_jam_skip) else $error("jam sync skip wrong");

  sequence s_pos_leap;
    tick_ok && fr_wrap && leap_now && !neg_q && seconds_q == SEC_LAST;
  endsequence
  property p_pos_leap;
    s_pos_leap |=> seconds_q == SEC_LEAP && leap_armed;
  endproperty
  a_pos_leap: assert property (p_pos_leap) else $error("second 60 not inserted");

  property p_neg_leap;
    tick_ok && fr_wrap && leap_now && neg_q && seconds_q == SEC_NEG_LAST
      |=> seconds_q == 6'h00 && !leap_armed;
  endproperty
  a_neg_leap: assert property (p_neg_leap) else $error("second 59 not skipped");

  property p_once_off;
    min_roll && once_hit && !summer_mode_wr |=> summer_mode == SM_OFF;
  endproperty
  a_once_off: assert property (p_once_off) else $error("one-shot did not disable");

  property p_jam_once;
    jam_done |=> !jam_done ##1 jam_fired_q || jam_clr;
  endproperty
  a_jam_once: assert property (p_jam_once) else $error("jam sync fired twice");

endmodule // timecode_time_of_day_adjust
